/* rtl/chf_host_port.sv */
`timescale 1ns/1ns
`include "chf_map.svh"
module chf_host_port #(
  parameter int CTL_AW = 5
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  // Host register port
  input  wire logic [2:0]               host_addr_i,
  input  wire logic                     host_wr_i,
  input  wire logic                     host_rd_i,
  input  wire chf_pkg::chf_word_t       host_wdata_i,
  output chf_pkg::chf_word_t            host_rdata_o,
  output logic                          host_rvalid_o,
  // Indirect register space
  output chf_pkg::chf_word_t            indirect_pointer_o,
  output logic                          ind_wr_o,
  output logic                          ind_rd_o,
  output chf_pkg::chf_byte_t            ind_wdata_o,
  input  wire chf_pkg::chf_byte_t       ind_rdata_i,
  // Transmit FIFO toward host
  input  wire chf_pkg::chf_word_t       txf_data_i,
  input  wire logic                     txf_last_i,
  input  wire logic                     txf_valid_i,
  output logic                          txf_ready_o,
  output logic                          txf_done_o,
  // Receive FIFO from host
  output chf_pkg::chf_word_t            rxf_data_o,
  output logic                          rxf_first_o,
  output logic                          rxf_last_o,
  output logic                          rxf_valid_o,
  input  wire logic                     rxf_ready_i,
  input  wire logic                     rxf_space_i,
  output logic                          rxf_realign_o,
  // Control receive buffer
  output logic                          crx_full_o,
  output logic [CTL_AW-1:0]             crx_len_o,
  input  wire logic [CTL_AW-1:0]        crx_raddr_i,
  output chf_pkg::chf_word_t            crx_rdata_o,
  input  wire logic                     crx_done_i,
  // Control transmit buffers
  input  wire logic                     ctx_wr_i,
  input  wire logic                     ctx_sel_i,
  input  wire logic [CTL_AW-1:0]        ctx_waddr_i,
  input  wire chf_pkg::chf_word_t       ctx_wdata_i,
  input  wire logic [1:0]               ctx_commit_i,
  output logic [1:0]                    ctx_full_o,
  // Device timeout event
  input  wire logic                     timeout_i
);
  localparam int DEPTH = 1 << CTL_AW;

  function automatic logic [CTL_AW-1:0] chf_inc(input logic [CTL_AW-1:0] p);
    chf_inc = CTL_AW'(p + 1'b1);
  endfunction

  logic wr_ptr, wr_data, wr_frame, wr_cmd, wr_irq, wr_buf1;
  logic rd_data, rd_frame, rd_buf1, rd_buf2;
  assign wr_ptr   = host_wr_i && host_addr_i == `CHF_A_PTR;
  assign wr_data  = host_wr_i && host_addr_i == `CHF_A_DATA;
  assign wr_frame = host_wr_i && host_addr_i == `CHF_A_FRAME;
  assign wr_cmd   = host_wr_i && host_addr_i == `CHF_A_CMD;
  assign wr_irq   = host_wr_i && host_addr_i == `CHF_A_IRQ;
  assign wr_buf1  = host_wr_i && host_addr_i == `CHF_A_BUF1;
  assign rd_data  = host_rd_i && host_addr_i == `CHF_A_DATA;
  assign rd_frame = host_rd_i && host_addr_i == `CHF_A_FRAME;
  assign rd_buf1  = host_rd_i && host_addr_i == `CHF_A_BUF1;
  assign rd_buf2  = host_rd_i && host_addr_i == `CHF_A_BUF2;

  logic cmd_crx, cmd_rel1, cmd_rel2, cmd_done, cmd_eof, cmd_align;
  assign cmd_crx   = wr_cmd && host_wdata_i[`CHF_B_CRX];
  assign cmd_rel1  = wr_cmd && host_wdata_i[`CHF_B_CTX1];
  assign cmd_rel2  = wr_cmd && host_wdata_i[`CHF_B_CTX2];
  assign cmd_done  = wr_cmd && host_wdata_i[`CHF_B_TXDONE];
  assign cmd_eof   = wr_cmd && host_wdata_i[`CHF_B_EOF];
  assign cmd_align = wr_cmd && host_wdata_i[`CHF_B_ALIGN];

  // Indirect access
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      indirect_pointer_o <= `CHF_PTR_RST;
      ind_wr_o           <= 1'b0;
      ind_wdata_o        <= '0;
    end else begin
      if (wr_ptr) begin
        indirect_pointer_o <= host_wdata_i;
      end
      ind_wr_o <= wr_data;
      if (wr_data) begin
        ind_wdata_o <= host_wdata_i[7:0];
      end
    end
  end
  assign ind_rd_o = rd_data;

  // Transmit FIFO pop and frame end
  logic tx_end;
  assign txf_ready_o = rd_frame;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_end     <= 1'b0;
      txf_done_o <= 1'b0;
    end else begin
      txf_done_o <= cmd_done;
      // Set wins so an end seen during the clear is kept
      if (rd_frame && txf_valid_i && txf_last_i) begin
        tx_end <= 1'b1;
      end else if (cmd_done) begin
        tx_end <= 1'b0;
      end
    end
  end

  // Two-entry receive buffer; host writes past full are dropped
  chf_pkg::chf_entry_t skid [2];
  logic       sk_wp, sk_rp;
  logic [1:0] sk_cnt;
  logic       eof_arm, frame_first, push, pop, rx_room;
  assign push    = wr_frame && sk_cnt != `CHF_SKID_FULL && !cmd_align;
  assign pop     = rxf_valid_o && rxf_ready_i;
  assign rx_room = sk_cnt != `CHF_SKID_FULL && rxf_space_i;
  assign rxf_valid_o = sk_cnt != 2'd0;
  assign {rxf_first_o, rxf_last_o, rxf_data_o} = skid[sk_rp];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || cmd_align) begin
      sk_wp  <= 1'b0;
      sk_rp  <= 1'b0;
      sk_cnt <= 2'd0;
    end else begin
      if (push) begin
        skid[sk_wp] <= {frame_first, eof_arm, host_wdata_i};
        sk_wp       <= ~sk_wp;
      end
      if (pop) begin
        sk_rp <= ~sk_rp;
      end
      sk_cnt <= sk_cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || cmd_align) begin
      eof_arm     <= 1'b0;
      frame_first <= 1'b1;
    end else begin
      if (cmd_eof) begin
        eof_arm <= 1'b1;
      end else if (push) begin
        eof_arm <= 1'b0;
      end
      if (push) begin
        frame_first <= eof_arm;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rxf_realign_o <= 1'b0;
    end else begin
      rxf_realign_o <= cmd_align;
    end
  end

  // Control receive buffer
  chf_pkg::chf_word_t crx_mem [DEPTH];
  logic [CTL_AW-1:0] crx_wp;
  always_ff @(posedge clk_sys_i) begin
    if (wr_buf1 && !crx_full_o) begin
      crx_mem[crx_wp] <= host_wdata_i;
    end
    crx_rdata_o <= crx_mem[crx_raddr_i];
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      crx_full_o <= 1'b0;
      crx_wp     <= '0;
      crx_len_o  <= '0;
    end else if (cmd_crx) begin
      crx_full_o <= 1'b1;
      crx_len_o  <= crx_wp;
    end else if (crx_done_i) begin
      crx_full_o <= 1'b0;
      crx_wp     <= '0;
    end else if (wr_buf1 && !crx_full_o) begin
      crx_wp <= chf_inc(crx_wp);
    end
  end

  // Control transmit buffers; device fills, host drains
  chf_pkg::chf_word_t ctx_mem [2][DEPTH];
  logic [CTL_AW-1:0] ctx_rp [2];
  logic [1:0] ctx_rd, ctx_rel;
  assign ctx_rd  = {rd_buf2, rd_buf1};
  assign ctx_rel = {cmd_rel2, cmd_rel1};
  always_ff @(posedge clk_sys_i) begin
    if (ctx_wr_i) begin
      ctx_mem[ctx_sel_i][ctx_waddr_i] <= ctx_wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        ctx_full_o[i] <= 1'b0;
        ctx_rp[i]     <= '0;
      end else if (ctx_commit_i[i]) begin
        ctx_full_o[i] <= 1'b1;
        ctx_rp[i]     <= '0;
      end else if (ctx_rel[i]) begin
        ctx_full_o[i] <= 1'b0;
        ctx_rp[i]     <= '0;
      end else if (ctx_rd[i] && ctx_full_o[i]) begin
        ctx_rp[i] <= chf_inc(ctx_rp[i]);
      end
    end
  end

  // Sticky timeout flag; a new timeout beats the clear
  logic tout;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tout <= 1'b0;
    end else if (timeout_i) begin
      tout <= 1'b1;
    end else if (wr_irq && !host_wdata_i[`CHF_B_TOUT]) begin
      tout <= 1'b0;
    end
  end

  // Read mux
  chf_pkg::chf_word_t rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (host_addr_i)
      `CHF_A_DATA:  rd_mux = {8'h00, ind_rdata_i};
      `CHF_A_FRAME: rd_mux = txf_valid_i ? txf_data_i : '0;
      `CHF_A_CMD:   rd_mux = {10'h000, tx_end, rx_room, txf_valid_i,
                              ctx_full_o, !crx_full_o};
      `CHF_A_IRQ:   rd_mux = {8'h00, tout, 4'h0, ctx_full_o, txf_valid_i};
      `CHF_A_BUF1:  rd_mux = ctx_full_o[0] ? ctx_mem[0][ctx_rp[0]] : '0;
      `CHF_A_BUF2:  rd_mux = ctx_full_o[1] ? ctx_mem[1][ctx_rp[1]] : '0;
      default:      rd_mux = '0;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_rdata_o  <= '0;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i) begin
        host_rdata_o <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_eof_word;
    cmd_eof ##1 push;
  endsequence
  sequence s_cmd_read;
    host_rd_i && host_addr_i == `CHF_A_CMD;
  endsequence
  a_ptr_load: assert property (wr_ptr |=> indirect_pointer_o == $past(host_wdata_i))
    else $error("pointer not loaded");
  a_data_read: assert property (rd_data |=> host_rdata_o[7:0] == $past(ind_rdata_i))
    else $error("indirect data wrong");
  a_frame_push: assert property (push && !pop |=> rxf_valid_o)
    else $error("frame word lost");
  a_crx_commit: assert property (cmd_crx |=> crx_full_o [*2] or (crx_full_o ##1 $past(crx_done_i)))
    else $error("receive buffer not committed");
  a_ctx_release: assert property (cmd_rel1 && !ctx_commit_i[0] |=> !ctx_full_o[0])
    else $error("buffer one not released");
  a_done_pulse: assert property (cmd_done |=> txf_done_o ##1 (!txf_done_o || $past(cmd_done)))
    else $error("done not self cleared");
  a_eof_mark: assert property (s_eof_word |=> !eof_arm)
    else $error("end mark stuck");
  a_align_flush: assert property (cmd_align |=> !rxf_valid_o && frame_first)
    else $error("realign did not flush");
  a_crx_status: assert property (s_cmd_read |=> host_rdata_o[0] == !$past(crx_full_o))
    else $error("receive free status wrong");
  a_tx_end: assert property (rd_frame && txf_valid_i && txf_last_i |=> tx_end)
    else $error("frame end not flagged");
  a_tout_sticky: assert property (tout && !wr_irq |=> tout)
    else $error("timeout flag lost");
  a_crx_hold: assert property (crx_full_o && !crx_done_i |=> crx_full_o)
    else $error("receive flag dropped early");
endmodule

/* common/chf_map.svh */
`ifndef CHF_MAP_SVH
`define CHF_MAP_SVH
`define CHF_A_PTR     3'h0
`define CHF_A_DATA    3'h2
`define CHF_A_FRAME   3'h3
`define CHF_A_CMD     3'h4
`define CHF_A_IRQ     3'h5
`define CHF_A_BUF1    3'h6
`define CHF_A_BUF2    3'h7
`define CHF_B_CRX     0
`define CHF_B_CTX1    1
`define CHF_B_CTX2    2
`define CHF_B_TXDONE  3
`define CHF_B_EOF     4
`define CHF_B_ALIGN   5
`define CHF_B_TOUT    7
`define CHF_SKID_FULL 2'd2
`define CHF_PTR_RST   16'h0000
`endif

/* common/chf_pkg.sv */
package chf_pkg;
  typedef logic [15:0] chf_word_t;
  typedef logic [7:0]  chf_byte_t;
  // Buffer entry: first flag, last flag, data
  typedef logic [17:0] chf_entry_t;
endpackage

/* dv/chf_far_model.sv */
`timescale 1ns/1ns
module chf_far_model (
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  // Bench controls
  input  wire logic               en_i,
  input  wire logic               stall_i,
  // Transmit FIFO source
  output chf_pkg::chf_word_t      txf_data_o,
  output logic                    txf_last_o,
  output logic                    txf_valid_o,
  input  wire logic               txf_ready_i,
  // Receive FIFO sink
  output logic                    rxf_ready_o,
  output logic                    rxf_space_o
);
  chf_pkg::chf_word_t idx;
  // Idle data inverted so a stale word never passes
  assign txf_valid_o = en_i;
  assign txf_data_o  = en_i ? 16'ha000 + idx : ~(16'ha000 + idx);
  assign txf_last_o  = idx[1:0] == 2'h3;
  assign rxf_ready_o = !stall_i;
  assign rxf_space_o = 1'b1;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      idx <= 16'h0000;
    end else if (txf_valid_o && txf_ready_i) begin
      idx <= idx + 16'h0001;
    end
  end
endmodule

/* dv/chf_host_port_tb.sv */
`timescale 1ns/1ns
module chf_host_port_tb;
  logic clk_sys_i, rst_i, host_wr_i, host_rd_i, host_rvalid_o, ind_wr_o, ind_rd_o;
  logic txf_last_i, txf_valid_i, txf_ready_o, txf_done_o, rxf_first_o, rxf_last_o;
  logic rxf_valid_o, rxf_ready_i, rxf_space_i, rxf_realign_o, crx_full_o, crx_done_i;
  logic ctx_wr_i, ctx_sel_i, timeout_i, en, stall;
  logic [2:0] host_addr_i;
  logic [1:0] ctx_commit_i, ctx_full_o;
  logic [4:0] crx_len_o, crx_raddr_i, ctx_waddr_i;
  logic [31:0] e;
  chf_pkg::chf_byte_t ind_wdata_o, ind_rdata_i;
  chf_pkg::chf_word_t host_wdata_i, host_rdata_o, indirect_pointer_o, txf_data_i;
  chf_pkg::chf_word_t rxf_data_o, crx_rdata_o, ctx_wdata_i, w;
  logic [31:0] rq[$];
  logic [17:0] xq[$];
  int mismatches, compares, i;

  chf_host_port #(.CTL_AW(5)) chf_host_port_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .indirect_pointer_o(indirect_pointer_o), .ind_wr_o(ind_wr_o), .ind_rd_o(ind_rd_o),
    .ind_wdata_o(ind_wdata_o), .ind_rdata_i(ind_rdata_i), .txf_data_i(txf_data_i),
    .txf_last_i(txf_last_i), .txf_valid_i(txf_valid_i), .txf_ready_o(txf_ready_o),
    .txf_done_o(txf_done_o), .rxf_data_o(rxf_data_o), .rxf_first_o(rxf_first_o),
    .rxf_last_o(rxf_last_o), .rxf_valid_o(rxf_valid_o), .rxf_ready_i(rxf_ready_i),
    .rxf_space_i(rxf_space_i), .rxf_realign_o(rxf_realign_o), .crx_full_o(crx_full_o),
    .crx_len_o(crx_len_o), .crx_raddr_i(crx_raddr_i), .crx_rdata_o(crx_rdata_o),
    .crx_done_i(crx_done_i), .ctx_wr_i(ctx_wr_i), .ctx_sel_i(ctx_sel_i),
    .ctx_waddr_i(ctx_waddr_i), .ctx_wdata_i(ctx_wdata_i), .ctx_commit_i(ctx_commit_i),
    .ctx_full_o(ctx_full_o), .timeout_i(timeout_i));
  chf_far_model chf_far_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .en_i(en),
    .stall_i(stall), .txf_data_o(txf_data_i), .txf_last_o(txf_last_i),
    .txf_valid_o(txf_valid_i), .txf_ready_i(txf_ready_o), .rxf_ready_o(rxf_ready_i),
    .rxf_space_o(rxf_space_i));

  task automatic give_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobes stay up until the next call, so one assignment per step
  task automatic xf(input logic wr, input logic rd, input logic [2:0] a,
                    input logic [15:0] d, input logic [15:0] ex, input logic [15:0] m);
    if (rd) rq.push_back({ex, m});
    host_wr_i = wr;
    host_rd_i = rd;
    host_addr_i = a;
    host_wdata_i = d;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    xf(1'b1, 1'b0, a, d, 16'h0000, 16'h0000);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] ex, input logic [15:0] m);
    xf(1'b0, 1'b1, a, 16'h0000, ex, m);
  endtask
  task automatic nop(input int n);
    repeat (n) xf(1'b0, 1'b0, 3'h0, 16'h0000, 16'h0000, 16'h0000);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #80000;
    mismatches++;
    give_verdict();
  end
  always @(posedge clk_sys_i) begin
    if (host_rvalid_o === 1'b1) begin
      e = rq.size() > 0 ? rq.pop_front() : 32'hffffffff;
      chk({16'h0000, host_rdata_o & e[15:0]}, {16'h0000, e[31:16]});
    end
    if (rxf_valid_o === 1'b1 && rxf_ready_i === 1'b1) begin
      chk({rxf_first_o, rxf_last_o, rxf_data_o}, xq.size() > 0 ? xq.pop_front() : 18'h3ffff);
    end
  end

  initial begin
    rst_i = 1'b1;
    {host_wr_i, host_rd_i, host_addr_i, host_wdata_i, ind_rdata_i} = '0;
    {crx_raddr_i, crx_done_i, ctx_wr_i, ctx_sel_i, ctx_waddr_i, ctx_wdata_i} = '0;
    {ctx_commit_i, timeout_i, en, stall} = '0;
    i = $urandom(32'h2406053b);
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    rd(3'h4, 16'h0011, 16'h00ff);
    w = $urandom;
    wr(3'h0, w);
    chk(indirect_pointer_o, w);
    rd(3'h0, 16'h0000, 16'hffff);
    ind_rdata_i = 8'($urandom);
    wr(3'h2, w);
    chk({ind_wr_o, ind_wdata_o}, {1'b1, w[7:0]});
    rd(3'h2, {8'h00, ind_rdata_i}, 16'h00ff);
    chk(ind_rd_o, 1'b1);
    en = 1'b1;
    rd(3'h5, 16'h0001, 16'h0081);
    for (i = 0; i < 3; i++) rd(3'h3, 16'ha000 + 16'(i), 16'hffff);
    // End flag rises once the last word has been taken
    rd(3'h3, 16'ha003, 16'hffff);
    rd(3'h4, 16'h0038, 16'h0038);
    en = 1'b0;
    wr(3'h4, 16'h0008);
    chk(txf_done_o, 1'b1);
    // Third word overflows the stalled two-entry buffer
    stall = 1'b1;
    for (i = 0; i < 3; i++) begin
      w = $urandom;
      if (i < 2) xq.push_back({i == 0, 1'b0, w});
      wr(3'h3, w);
    end
    rd(3'h4, 16'h0000, 16'h0010);
    stall = 1'b0;
    nop(3);
    wr(3'h4, 16'h0010);
    for (i = 0; i < 2; i++) begin
      w = $urandom;
      xq.push_back({i == 1, i == 0, w});
      wr(3'h3, w);
    end
    nop(2);
    wr(3'h4, 16'h0020);
    chk(rxf_realign_o, 1'b1);
    w = $urandom;
    xq.push_back({2'b10, w});
    wr(3'h3, w);
    for (i = 0; i < 3; i++) wr(3'h6, 16'hc000 + 16'(i));
    wr(3'h4, 16'h0001);
    chk({crx_full_o, crx_len_o}, {1'b1, 5'd3});
    rd(3'h4, 16'h0000, 16'h0001);
    crx_raddr_i = 5'd1;
    nop(2);
    chk(crx_rdata_o, 16'hc001);
    crx_done_i = 1'b1;
    nop(1);
    crx_done_i = 1'b0;
    rd(3'h4, 16'h0001, 16'h0001);
    for (i = 0; i < 3; i++) begin
      ctx_wr_i = 1'b1;
      ctx_sel_i = i == 2;
      ctx_waddr_i = 5'(i % 2);
      ctx_wdata_i = 16'hb000 + 16'(i);
      nop(1);
    end
    ctx_wr_i = 1'b0;
    ctx_commit_i = 2'b11;
    nop(1);
    ctx_commit_i = 2'b00;
    rd(3'h4, 16'h0006, 16'h0006);
    rd(3'h5, 16'h0006, 16'h0006);
    rd(3'h6, 16'hb000, 16'hffff);
    rd(3'h6, 16'hb001, 16'hffff);
    wr(3'h4, 16'h0002);
    chk(ctx_full_o, 2'b10);
    rd(3'h6, 16'h0000, 16'hffff);
    rd(3'h7, 16'hb002, 16'hffff);
    wr(3'h4, 16'h0004);
    chk(ctx_full_o, 2'b00);
    timeout_i = 1'b1;
    nop(1);
    timeout_i = 1'b0;
    rd(3'h5, 16'h0080, 16'h0080);
    wr(3'h5, 16'h0080);
    rd(3'h5, 16'h0080, 16'h0080);
    wr(3'h5, 16'h0000);
    rd(3'h5, 16'h0000, 16'h0080);
    // Mid-run reset must return pointer and status to idle
    wr(3'h0, 16'h5a5a);
    rst_i = 1'b1;
    nop(2);
    rst_i = 1'b0;
    chk(indirect_pointer_o, 16'h0000);
    rd(3'h4, 16'h0011, 16'h00ff);
    nop(4);
    chk(rq.size() + xq.size(), 32'h0);
    give_verdict();
  end
endmodule
